//--- bts_pkg.sv
// Shared constants, register map and types for the battery test sequencer
package bts_pkg;
  // Widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LVL_W  = 16;
  localparam int MEAS_W = 16;
  localparam int TIME_W = 19;
  localparam int ACC_W  = 44;
  localparam int MODE_W = 2;
  localparam int MODE_N = 4;
  localparam int LVL_N  = 8;
  // Clock and tick timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES   = TICK_PERIOD_S * 1_000_000_000 / CLK_PERIOD_NS;
  // Elapsed time span in hours, counted in seconds
  localparam int TIME_SPAN_H = 100;
  localparam logic [TIME_W-1:0] TIME_MAX = TIME_W'(TIME_SPAN_H * 3600);
  // Capacity bound in units; accumulators count milli-units times milliseconds
  localparam longint ACC_CAP_UNITS = 1000;
  localparam logic [ACC_W-1:0] ACC_MAX = ACC_W'(ACC_CAP_UNITS * 64'd3600 * 64'd1_000_000);
  // Level ranges: fine is narrow with full resolution, coarse is wide
  localparam logic [LVL_W-1:0] FINE_MIN    = 16'h0000;
  localparam logic [LVL_W-1:0] FINE_MAX    = 16'h0FFF;
  localparam logic [LVL_W-1:0] COARSE_MIN  = 16'h0010;
  localparam logic [LVL_W-1:0] COARSE_MAX  = 16'hFFF0;
  localparam logic [LVL_W-1:0] COARSE_MASK = 16'hFFF0;
  localparam logic             RANGE_FINE  = 1'b0;
  // Reset values of thresholds
  localparam logic [LVL_W-1:0] CUTOFF_RST  = 16'h0000;
  localparam logic [LVL_W-1:0] DROPOUT_RST = 16'h0000;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_MODE    = 8'h00;
  localparam logic [ADDR_W-1:0] REG_RANGE   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_ACTSEL  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_LEVEL_A = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_LEVEL_B = 8'h10;
  localparam logic [ADDR_W-1:0] REG_CUTOFF  = 8'h14;
  localparam logic [ADDR_W-1:0] REG_DROPOUT = 8'h18;
  localparam logic [ADDR_W-1:0] REG_CMD     = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h20;
  localparam logic [ADDR_W-1:0] REG_TIME    = 8'h24;
  localparam logic [ADDR_W-1:0] REG_WH_LO   = 8'h28;
  localparam logic [ADDR_W-1:0] REG_WH_HI   = 8'h2C;
  localparam logic [ADDR_W-1:0] REG_AH_LO   = 8'h30;
  localparam logic [ADDR_W-1:0] REG_AH_HI   = 8'h34;
  localparam logic [ADDR_W-1:0] REG_IRQ_ST  = 8'h38;
  localparam logic [ADDR_W-1:0] REG_IRQ_EN  = 8'h3C;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 8'h40;
  localparam logic [ADDR_W-1:0] REG_EDIT    = 8'h44;
  // Command register bits
  localparam int CMD_RUN    = 0;
  localparam int CMD_STOP   = 1;
  localparam int CMD_CLEAR  = 2;
  localparam int CMD_IN_ON  = 3;
  localparam int CMD_IN_OFF = 4;
  // Interrupt status bits
  localparam int IRQ_CUTOFF = 0;
  localparam int IRQ_SAT    = 1;
  localparam int IRQ_TFULL  = 2;
  localparam int IRQ_REFUSE = 3;
  localparam int IRQ_N      = 4;
  // Load operating modes and test states
  typedef enum logic [MODE_W-1:0] {
    fixed_current_mode, fixed_power_mode, fixed_resistance_mode, fixed_voltage_mode
  } bts_mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_PAUSE, ST_CUTOFF} bts_state_t;
endpackage : bts_pkg

//--- bts_acc_if.sv
// Carrier between the sequencer core and one capacity accumulator
`timescale 1ns/1ps
interface bts_acc_if import bts_pkg::*; ();
  logic             clr;    // Clear to zero
  logic             en;     // Add inc this cycle
  logic [ACC_W-1:0] inc;    // Scaled sample
  logic [ACC_W-1:0] value;  // Present total
  logic             sat;    // Total sits at its bound
  modport core (output clr, output en, output inc, input value, input sat);
  modport acc  (input clr, input en, input inc, output value, output sat);
endinterface : bts_acc_if

//--- bts_accum.sv
// Saturating capacity accumulator
`timescale 1ns/1ps
module bts_accum import bts_pkg::*; (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  bts_acc_if.acc    acc
);
  logic [ACC_W-1:0] value_r;    // Running total
  logic [ACC_W-1:0] value_nxt;  // Next total
  logic [ACC_W:0]   sum_w;      // Extra bit so a wrap cannot hide an overflow

  assign sum_w     = {1'b0, value_r} + {1'b0, acc.inc};
  assign value_nxt = acc.clr ? '0 :
                     !acc.en ? value_r :
                     (sum_w >= {1'b0, ACC_MAX}) ? ACC_MAX : sum_w[ACC_W-1:0];
  assign acc.value = value_r;
  assign acc.sat   = (value_r == ACC_MAX);

  // Total register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      value_r <= '0;
    end else begin
      value_r <= value_nxt;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_acc_bound: assert property (value_r <= ACC_MAX)
    else $error("accumulator above its bound");
  a_acc_hold: assert property (!acc.en && !acc.clr |=> $stable(value_r))
    else $error("accumulator moved while disabled");
endmodule : bts_accum

//--- bts_tick.sv
// Restartable one-second tick generator
`timescale 1ns/1ps
module bts_tick import bts_pkg::*; #(
  parameter int unsigned CYCLES = TICK_CYCLES  // At least 2
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic restart,
  output logic      tick
);
  localparam int CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] cnt_r;   // Cycle count within the second
  logic          tick_r;  // One-cycle tick
  wire           wrap_w = (cnt_r == LAST);

  // Counter restarts with a clear, so the first second counts from the clear, not from the run
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= (restart || wrap_w) ? '0 : cnt_r + 1'b1;
      tick_r <= wrap_w && !restart;
    end
  end
  assign tick = tick_r;
endmodule : bts_tick

//--- bts_seq.sv
// Battery discharge test sequencer: register slave, levels, cut-off and capacity
// Behaviour
// - Test refused in fixed voltage mode
// - Watt-hour and amp-hour totals saturate at 1000
// - Two level ranges, one in fixed power
// - Applying a range disables load input
// - Coarser range drops low level bits
// - Out-of-range levels clamp to range bounds
// - Each mode keeps its own level pair
// - Show last edited level; allow activating it
// - Below cut-off voltage disables load input
// - Run enables input, starts timer and totals
// - Timer counts seconds up to 100 hours
// - Stop disables input, freezes timer and totals
// - Run after stop resumes from frozen values
// - Reset clears timer and both totals
// - Cut-off during run ends and freezes test
// - No conduction below dropout except in fixed voltage mode, not latched
`timescale 1ns/1ps
module bts_seq import bts_pkg::*; #(
  parameter int unsigned TICK_CYC  = TICK_CYCLES,  // Cycles per second tick
  parameter int unsigned SAMPLE_MS = 1             // Measurement sample interval
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic [LVL_W-1:0]  vsense_pin,
  input  wire logic              meas_valid,
  input  wire logic [MEAS_W-1:0] meas_power,
  input  wire logic [MEAS_W-1:0] meas_current,
  output logic                   load_en,
  output logic                   conduct,
  output logic      [LVL_W-1:0]  level_out,
  output logic                   irq
);
  // Software state
  bts_mode_t         mode_r;        // Selected load mode
  logic [MODE_N-1:0] range_r;       // Range per mode, 1 = coarse
  logic [MODE_N-1:0] act_r;         // Active level per mode, 1 = B
  logic [MODE_N-1:0] edit_r;        // Last edited level per mode, 1 = B
  logic [LVL_W-1:0]  lvl_r [LVL_N]; // Level pairs, index {mode, level}
  logic [LVL_W-1:0]  cutoff_r;      // Cut-off threshold
  logic [LVL_W-1:0]  dropout_r;     // Dropout threshold
  logic [IRQ_N-1:0]  irq_st_r;      // Sticky event bits
  logic [IRQ_N-1:0]  irq_en_r;      // Interrupt enables
  // Block state
  bts_state_t        state_r;       // Test sequence state
  bts_state_t        state_nxt;
  logic              load_en_r;     // Load input enable
  logic              load_en_nxt;
  logic              conduct_r;     // Power stage conducting
  logic [LVL_W-1:0]  level_r;       // Demand presented to the power stage
  logic [TIME_W-1:0] time_r;        // Elapsed seconds
  logic [TIME_W-1:0] time_nxt;
  logic [LVL_W-1:0]  vs_meta_r;     // Sense synchroniser, first stage
  logic [LVL_W-1:0]  vs_sync_r;     // Sense synchroniser, second stage
  logic [DATA_W-1:0] rdata_r;       // Read data, valid one cycle
  logic [DATA_W-1:0] rd_mux_w;      // Selected read value
  logic              wh_sat_d_r;    // Saturation seen last cycle
  logic              ah_sat_d_r;
  logic              tick_w;        // One-second tick

  bts_acc_if wh_if ();
  bts_acc_if ah_if ();

  // Write decode
  wire wr_mode  = reg_wr && (reg_addr == REG_MODE);
  wire wr_range = reg_wr && (reg_addr == REG_RANGE);
  wire wr_act   = reg_wr && (reg_addr == REG_ACTSEL);
  wire wr_lvla  = reg_wr && (reg_addr == REG_LEVEL_A);
  wire wr_lvlb  = reg_wr && (reg_addr == REG_LEVEL_B);
  wire wr_cut   = reg_wr && (reg_addr == REG_CUTOFF);
  wire wr_drop  = reg_wr && (reg_addr == REG_DROPOUT);
  wire wr_cmd   = reg_wr && (reg_addr == REG_CMD);
  wire wr_ien   = reg_wr && (reg_addr == REG_IRQ_EN);
  wire wr_iclr  = reg_wr && (reg_addr == REG_IRQ_CLR);
  wire wr_lvl   = wr_lvla || wr_lvlb;

  // Command decode
  wire cmd_run    = wr_cmd && reg_wdata[CMD_RUN];
  wire cmd_stop   = wr_cmd && reg_wdata[CMD_STOP];
  wire cmd_clear  = wr_cmd && reg_wdata[CMD_CLEAR];
  wire cmd_in_on  = wr_cmd && reg_wdata[CMD_IN_ON];
  wire cmd_in_off = wr_cmd && reg_wdata[CMD_IN_OFF];
  wire is_volt    = (mode_r == fixed_voltage_mode);
  wire refuse     = cmd_run && is_volt;
  wire run_ok     = cmd_run && !is_volt;

  // Range apply: fixed power has one range, so writes there are ignored
  wire rng_new    = reg_wdata[0];
  wire rng_apply  = wr_range && (mode_r != fixed_power_mode);
  wire act_now    = act_r[mode_r];

  // Threshold compares on the synchronised sense voltage
  wire below_cut  = (vs_sync_r < cutoff_r);
  wire below_drop = (vs_sync_r < dropout_r);
  wire running    = (state_r == ST_RUN);
  wire trip       = below_cut && running;
  wire time_full  = (time_r == TIME_MAX);

  // Trims a value to the target range: coarse drops low bits, then clamp
  function automatic logic [LVL_W-1:0] fit_level(input logic [LVL_W-1:0] v,
                                                 input logic rng);
    logic [LVL_W-1:0] t;
    logic [LVL_W-1:0] lo;
    logic [LVL_W-1:0] hi;
    t  = rng ? (v & COARSE_MASK) : v;
    lo = rng ? COARSE_MIN : FINE_MIN;
    hi = rng ? COARSE_MAX : FINE_MAX;
    return (t > hi) ? hi : ((t < lo) ? lo : t);
  endfunction : fit_level

  // Sense synchroniser: the pin is asynchronous to sys_clk
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      vs_meta_r <= '0;
      vs_sync_r <= '0;
    end else begin
      vs_meta_r <= vsense_pin;
      vs_sync_r <= vs_meta_r;
    end
  end

  // Mode, thresholds and enables; mode is locked while a test runs
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r    <= fixed_current_mode;
      cutoff_r  <= CUTOFF_RST;
      dropout_r <= DROPOUT_RST;
      irq_en_r  <= '0;
    end else begin
      if (wr_mode && !running) mode_r <= bts_mode_t'(reg_wdata[MODE_W-1:0]);
      if (wr_cut)  cutoff_r  <= reg_wdata[LVL_W-1:0];
      if (wr_drop) dropout_r <= reg_wdata[LVL_W-1:0];
      if (wr_ien)  irq_en_r  <= reg_wdata[IRQ_N-1:0];
    end
  end

  // Per-mode range, active level and last edited level
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      range_r <= '0;
      act_r   <= '0;
      edit_r  <= '0;
    end else begin
      if (rng_apply) range_r[mode_r] <= rng_new;
      if (wr_act)    act_r[mode_r]   <= reg_wdata[0];
      if (wr_lvl)    edit_r[mode_r]  <= wr_lvlb;
    end
  end

  // Level storage: one register per mode and level so mode changes keep pairs
  for (genvar gi = 0; gi < LVL_N; gi++) begin : g_lvl
    localparam logic [MODE_W-1:0] GM = MODE_W'(gi / 2);
    localparam logic              GL = 1'(gi % 2);
    wire own = (mode_r == bts_mode_t'(GM));
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        lvl_r[gi] <= FINE_MIN;
      end else if (own && rng_apply) begin
        lvl_r[gi] <= fit_level(lvl_r[gi], rng_new);
      end else if (own && wr_lvl && (wr_lvlb == GL)) begin
        lvl_r[gi] <= fit_level(reg_wdata[LVL_W-1:0], range_r[GM]);
      end
    end
  end

  // Test sequence; cut-off wins over every command in the same cycle
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RUN: begin
        if (trip) begin
          state_nxt = ST_CUTOFF;
        end else if (cmd_stop || rng_apply || cmd_in_off) begin
          state_nxt = ST_PAUSE;
        end
      end
      ST_CUTOFF: begin
        if (run_ok) begin
          state_nxt = ST_RUN;
        end else if (cmd_clear) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE, ST_PAUSE: begin
        if (run_ok) begin
          state_nxt = ST_RUN;
        end
      end
    endcase
  end

  // Load input enable: every way of turning it off beats turning it on; the
  // cut-off gate is unconditional so a run or input-on cannot slip one cycle in
  assign load_en_nxt = below_cut                ? 1'b0 :
                       rng_apply                ? 1'b0 :
                       (cmd_stop || cmd_in_off) ? 1'b0 :
                       (run_ok || cmd_in_on)    ? 1'b1 :
                       load_en_r;

  // Elapsed time: clear first, then count ticks while running, stop at the cap
  assign time_nxt = cmd_clear ? '0 :
                    (running && tick_w && !time_full) ? time_r + 1'b1 :
                    time_r;

  // Sequencer registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r   <= ST_IDLE;
      load_en_r <= 1'b0;
      time_r    <= '0;
    end else begin
      state_r   <= state_nxt;
      load_en_r <= load_en_nxt;
      time_r    <= time_nxt;
    end
  end

  // Power stage drive; dropout is a live gate, not a latch, and has no meaning
  // in fixed voltage mode
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      conduct_r <= 1'b0;
      level_r   <= FINE_MIN;
    end else begin
      conduct_r <= load_en_r && (is_volt || !below_drop);
      level_r   <= lvl_r[{mode_r, act_now}];
    end
  end

  // Capacity accumulators: each sample adds reading times interval
  assign wh_if.clr = cmd_clear;
  assign ah_if.clr = cmd_clear;
  assign wh_if.en  = running && meas_valid;
  assign ah_if.en  = running && meas_valid;
  assign wh_if.inc = ACC_W'(meas_power) * ACC_W'(SAMPLE_MS);
  assign ah_if.inc = ACC_W'(meas_current) * ACC_W'(SAMPLE_MS);

  bts_accum u_wh (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .acc     (wh_if.acc)
  );

  bts_accum u_ah (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .acc     (ah_if.acc)
  );

  bts_tick #(
    .CYCLES (TICK_CYC)
  ) u_tick (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .restart (cmd_clear),
    .tick    (tick_w)
  );

  // Interrupt events; a new event in the clear cycle survives the clear
  wire sat_ev = (wh_if.sat && !wh_sat_d_r) || (ah_if.sat && !ah_sat_d_r);
  wire [IRQ_N-1:0] irq_ev = {refuse,
                             running && tick_w && (time_nxt == TIME_MAX) && !time_full,
                             sat_ev,
                             trip};
  wire [IRQ_N-1:0] irq_clr = wr_iclr ? reg_wdata[IRQ_N-1:0] : '0;

  // Sticky status and saturation edge history
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_st_r   <= '0;
      wh_sat_d_r <= 1'b0;
      ah_sat_d_r <= 1'b0;
    end else begin
      irq_st_r   <= (irq_st_r & ~irq_clr) | irq_ev;
      wh_sat_d_r <= wh_if.sat;
      ah_sat_d_r <= ah_if.sat;
    end
  end

  // Read selection; the edit register shows the level edited last
  wire [7:0] status_w = {below_cut, edit_r[mode_r], act_now, range_r[mode_r],
                         conduct_r, load_en_r, state_r};
  assign rd_mux_w =
    (reg_addr == REG_MODE)    ? DATA_W'(mode_r) :
    (reg_addr == REG_RANGE)   ? DATA_W'(range_r[mode_r]) :
    (reg_addr == REG_ACTSEL)  ? DATA_W'(act_now) :
    (reg_addr == REG_LEVEL_A) ? DATA_W'(lvl_r[{mode_r, 1'b0}]) :
    (reg_addr == REG_LEVEL_B) ? DATA_W'(lvl_r[{mode_r, 1'b1}]) :
    (reg_addr == REG_CUTOFF)  ? DATA_W'(cutoff_r) :
    (reg_addr == REG_DROPOUT) ? DATA_W'(dropout_r) :
    (reg_addr == REG_STATUS)  ? DATA_W'(status_w) :
    (reg_addr == REG_TIME)    ? DATA_W'(time_r) :
    (reg_addr == REG_WH_LO)   ? wh_if.value[DATA_W-1:0] :
    (reg_addr == REG_WH_HI)   ? DATA_W'(wh_if.value[ACC_W-1:DATA_W]) :
    (reg_addr == REG_AH_LO)   ? ah_if.value[DATA_W-1:0] :
    (reg_addr == REG_AH_HI)   ? DATA_W'(ah_if.value[ACC_W-1:DATA_W]) :
    (reg_addr == REG_IRQ_ST)  ? DATA_W'(irq_st_r) :
    (reg_addr == REG_IRQ_EN)  ? DATA_W'(irq_en_r) :
    (reg_addr == REG_EDIT)    ? DATA_W'(lvl_r[{mode_r, edit_r[mode_r]}]) :
    '0;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= reg_rd ? rd_mux_w : '0;
    end
  end

  // Outputs
  assign reg_rdata = rdata_r;
  assign load_en   = load_en_r;
  assign conduct   = conduct_r;
  assign level_out = level_r;
  assign irq       = |(irq_st_r & irq_en_r);

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_no_volt_run: assert property (running |-> !is_volt)
    else $error("test running in fixed voltage mode");
  a_power_one_rng: assert property (range_r[fixed_power_mode] == RANGE_FINE)
    else $error("fixed power mode left its single range");
  a_range_off: assert property (rng_apply |=> !load_en_r && !running)
    else $error("range applied with load input still on");
  a_coarse_trim: assert property (rng_apply && rng_new
      |=> (lvl_r[{mode_r, 1'b0}] & ~COARSE_MASK) == '0)
    else $error("coarse range kept low level bits");
  a_fine_clamp: assert property (rng_apply && !rng_new
      |=> lvl_r[{mode_r, 1'b1}] <= FINE_MAX)
    else $error("level above fine range maximum");
  a_cut_trip: assert property (below_cut |=> !load_en_r)
    else $error("load input on below cut-off");
  a_run_start: assert property (run_ok && !below_cut && !running
      |=> running && load_en_r)
    else $error("run did not start the test");
  a_time_cap: assert property (time_r <= TIME_MAX)
    else $error("elapsed time beyond span");
  a_pause_hold: assert property (state_r == ST_PAUSE && !cmd_clear
      |=> time_r == $past(time_r))
    else $error("timer moved while paused");
  a_clear_zero: assert property (cmd_clear |=> time_r == '0 && wh_if.value == '0)
    else $error("clear left timer or total");
  a_cut_end: assert property (trip |=> state_r == ST_CUTOFF && !load_en_r)
    else $error("cut-off did not end the test");
  a_tick_only: assert property (!cmd_clear && !(running && tick_w) |=> $stable(time_r))
    else $error("timer advanced without a running tick");
endmodule : bts_seq

//--- bts_cell_model.sv
// Behavioural battery cell seen through the load input
`timescale 1ns/1ps
module bts_cell_model import bts_pkg::*; (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              conduct,       // Load stage drawing current
  input  wire logic [LVL_W-1:0]  v_set,         // Open-circuit cell voltage code
  output logic      [LVL_W-1:0]  vsense_pin,
  output logic                   meas_valid,
  output logic      [MEAS_W-1:0] meas_power,
  output logic      [MEAS_W-1:0] meas_current
);
  logic [1:0] div_r;  // Sample divider, one sample every fourth cycle
  // Voltage follows the cell; samples only mean anything while current flows
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r      <= 2'd0;
      meas_valid <= 1'b0;
    end else begin
      div_r      <= div_r + 2'd1;
      meas_valid <= conduct && (div_r == 2'd3);
    end
  end
  assign vsense_pin   = v_set;
  // Away from a sample the lines toggle so that stale values are never trusted
  assign meas_power   = meas_valid ? 16'h0010 : {8'hA5, 6'h00, div_r};
  assign meas_current = meas_valid ? 16'h0002 : {8'h5A, 6'h00, div_r};
endmodule : bts_cell_model

//--- tb.sv
// Self-checking bench for the battery test sequencer
`timescale 1ns/1ps
module tb import bts_pkg::*; ;
  logic              sys_clk = 1'b0;
  logic              rst_b = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [LVL_W-1:0]  vsense_pin;
  logic [LVL_W-1:0]  v_set = 16'h8000;
  logic              meas_valid;
  logic [MEAS_W-1:0] meas_power;
  logic [MEAS_W-1:0] meas_current;
  logic              load_en, conduct, irq;
  logic [LVL_W-1:0]  level_out;
  int                err_count = 0;
  int                n_tests = 0;
  logic [DATA_W-1:0] d, t1, t2;
  always #5 sys_clk = ~sys_clk;
  // Short tick keeps the timer scenario within a few hundred cycles
  bts_seq #(.TICK_CYC(20), .SAMPLE_MS(1)) bts_seq_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .vsense_pin(vsense_pin), .meas_valid(meas_valid),
    .meas_power(meas_power), .meas_current(meas_current), .load_en(load_en),
    .conduct(conduct), .level_out(level_out), .irq(irq));
  bts_cell_model bts_cell_model_i (.sys_clk(sys_clk), .rst_b(rst_b), .conduct(conduct),
    .v_set(v_set), .vsense_pin(vsense_pin), .meas_valid(meas_valid),
    .meas_power(meas_power), .meas_current(meas_current));
  // One-cycle write strobe
  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge sys_clk);
    reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // One-cycle read strobe; data stands only in the following cycle
  task rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge sys_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task chk(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      err_count++;
    end
  endtask : chk
  task settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : settle
  task t_refuse;
    wr(REG_MODE, 32'h0000_0003); wr(REG_IRQ_EN, 32'h0000_0008); wr(REG_CMD, 32'h0000_0001);
    settle(2);
    chk("load_en", load_en, 1'b0);
    chk("irq", irq, 1'b1);
    rd(REG_IRQ_ST, d); chk("irq_st", d[IRQ_REFUSE], 1'b1);
    wr(REG_IRQ_CLR, 32'h0000_0008); settle(1); chk("irq_clr", irq, 1'b0);
    wr(REG_MODE, 32'h0000_0000);
    $display("test refuse done");
  endtask : t_refuse
  task t_run_stop;
    wr(REG_CMD, 32'h0000_0001); settle(1); chk("run_en", load_en, 1'b1);
    settle(100); wr(REG_CMD, 32'h0000_0002); settle(1); chk("stop_en", load_en, 1'b0);
    rd(REG_TIME, t1); rd(REG_WH_LO, d); settle(100); rd(REG_TIME, t2);
    chk("time_frz", t2, t1);
    rd(REG_WH_LO, t2); chk("wh_frz", t2, d);
    chk("time_run", (t1 >= 32'd4 && t1 <= 32'd6), 1'b1);
    wr(REG_CMD, 32'h0000_0001); settle(100); wr(REG_CMD, 32'h0000_0002);
    rd(REG_TIME, t2); chk("time_res", (t2 - t1 >= 4 && t2 - t1 <= 6), 1'b1);
    rd(REG_WH_LO, t2); chk("wh_res", (t2 > d && d != 0), 1'b1);
    rd(REG_WH_LO, d); rd(REG_AH_LO, t2); chk("ah_rate", t2 * 8, d);
    wr(REG_CMD, 32'h0000_0004); rd(REG_TIME, d); chk("clr_t", d, 32'h0000_0000);
    rd(REG_WH_LO, d); chk("clr_wh", d, 32'h0000_0000);
    rd(REG_AH_LO, d); chk("clr_ah", d, 32'h0000_0000);
    $display("test run_stop done");
  endtask : t_run_stop
  task t_range;
    wr(REG_LEVEL_A, 32'h0000_1234); rd(REG_LEVEL_A, d); chk("fine_clamp", d, 32'h0FFF);
    wr(REG_LEVEL_B, 32'h0000_0123); rd(REG_EDIT, d); chk("edit", d, 32'h0000_0123);
    wr(REG_ACTSEL, 32'h0000_0001); settle(2); chk("act_b", level_out, 16'h0123);
    wr(REG_CMD, 32'h0000_0001); wr(REG_RANGE, 32'h0000_0001); settle(1);
    chk("rng_off", load_en, 1'b0);
    rd(REG_LEVEL_A, d); chk("trunc_a", d, 32'h0000_0FF0);
    rd(REG_LEVEL_B, d); chk("trunc_b", d, 32'h0000_0120);
    wr(REG_MODE, 32'h0000_0001); wr(REG_RANGE, 32'h0000_0001);
    rd(REG_RANGE, d); chk("pwr_rng", d, 32'h0000_0000);
    wr(REG_LEVEL_A, 32'h0000_0055); wr(REG_MODE, 32'h0000_0000);
    rd(REG_LEVEL_A, d); chk("mode_keep", d, 32'h0000_0FF0);
    wr(REG_RANGE, 32'h0000_0000); wr(REG_CMD, 32'h0000_0004);
    $display("test range done");
  endtask : t_range
  task t_dropout;
    wr(REG_DROPOUT, 32'h0000_4000); wr(REG_CMD, 32'h0000_0008); v_set <= 16'h2000; settle(6);
    chk("drop_off", conduct, 1'b0); chk("drop_en", load_en, 1'b1);
    v_set <= 16'h8000; settle(6); chk("drop_back", conduct, 1'b1);
    wr(REG_DROPOUT, 32'h0000_0000); wr(REG_CMD, 32'h0000_0010);
    $display("test dropout done");
  endtask : t_dropout
  task t_cutoff;
    int i;
    wr(REG_CUTOFF, 32'h0000_1000); wr(REG_CMD, 32'h0000_0001); v_set <= 16'h0800;
    // Let the run settle first, or the wait below would see the old, idle enable
    settle(1); chk("cut_on", load_en, 1'b1);
    // Bounded wait for the trip; the loop limit stands in for a hang
    for (i = 0; i < 10 && load_en !== 1'b0; i++) settle(1);
    chk("cut_en", load_en, 1'b0);
    rd(REG_STATUS, d); chk("cut_st", d[1:0], 2'd3);
    rd(REG_IRQ_ST, d); chk("cut_irq", d[IRQ_CUTOFF], 1'b1);
    rd(REG_TIME, t1); settle(40); rd(REG_TIME, t2); chk("cut_frz", t2, t1);
    v_set <= 16'h8000; wr(REG_CMD, 32'h0000_0004);
    $display("test cutoff done");
  endtask : t_cutoff
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_refuse; t_run_stop; t_range; t_dropout; t_cutoff;
    stop_test;
  end
endmodule : tb
